// ==== inc/prom_prog_pkg.sv ====
/*
 * Constants for the fuse PROM programmer and reader: timing figures, their cycle counts,
 * and the sequencer state codes.
 * Assumes a 250 MHz system clock. The times are least times, so the cycle counts round up.
 */
package prom_prog_pkg;
    localparam int CLK_MHZ = 250;
    localparam int STEP_DELAY_US = 10;
    localparam int FUSE_PULSE_US = 1000;
    localparam int REST_US = 3000;
    localparam int SETTLE_NS = 200;
    localparam int STEP_DELAY_CYC = STEP_DELAY_US * CLK_MHZ;
    localparam int FUSE_PULSE_CYC = FUSE_PULSE_US * CLK_MHZ;
    localparam int REST_CYC = REST_US * CLK_MHZ;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 9;
    localparam logic [1:0] SUPPLY_OFF = 2'h0;
    localparam logic [1:0] SUPPLY_PROG = 2'h1;
    localparam logic [1:0] SUPPLY_UPPER = 2'h2;
    localparam logic [1:0] SUPPLY_LOWER = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ARM = 4'h2,
        ST_SRC = 4'h3,
        ST_PULSE = 4'h4,
        ST_HOLD = 4'h5,
        ST_DISARM = 4'h6,
        ST_VERIFY_HI = 4'h7,
        ST_VERIFY_LO = 4'h8,
        ST_REST = 4'h9,
        ST_READ = 4'hA
    } prog_state_t;
endpackage : prom_prog_pkg

// ==== logic/wait_timer.sv ====
/*
 * Down-counting delay timer, loaded with a cycle count, pulses done when it runs out.
 * Assumes the loader waits for done before it loads the timer again.
 */
`timescale 1ns/1ns
module wait_timer #(
    parameter int WIDTH = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);
    logic [WIDTH-1:0] remain_r;
    logic busy_r;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            remain_r <= '0;
            busy_r <= 1'b0;
            done <= 1'b0;
        end else if (load) begin
            remain_r <= count;
            busy_r <= 1'b1;
            done <= 1'b0;
        end else if (busy_r && remain_r <= WIDTH'(1)) begin
            busy_r <= 1'b0;
            done <= 1'b1;
        end else begin
            remain_r <= remain_r - WIDTH'(1);
            done <= 1'b0;
        end
    end
endmodule : wait_timer

// ==== logic/prom_programmer.sv ====
/*
 * Host-side controller for a byte-wide fuse PROM with output latches. It reads words
 * (plain or latched) and fuses bits, stepping through the arm, source, pulse and verify
 * sequence and then resting between cycles.
 * Assumes PROM data pins come back synchronous to clk_sys. Supply selection, the fusing
 * source and the pin voltages are handled by outside analog switches driven from these ports.
 */
// Contract
// [R1] Strobe high makes the part a plain combinational ROM gated by enables.
// [R2] Strobe low holds the word addressed at that moment.
// [R3] Only a strobe rise loads new data and captures the enable state.
// [R4] Outputs float when either chip select is inactive.
// [R5] Blank bits read 0; fusing only sets bits to 1.
// [R6] Selects active and strobe high throughout fusing.
// [R7] Programming supply and address, then 10 us, then raise fuse arm.
// [R8] 10 us after arming, source one output only.
// [R9] 10 us after source, pulse fuse input high for 1 ms.
// [R10] 10 us after the pulse ends, remove the fusing source.
// [R11] After 10 us lower arm; verify the bit reads 1 at both levels.
// [R12] Back to programming supply for each further bit, then other addresses.
// [R13] Rest 3 ms with supply off after each program-verify cycle.
// [R14] Latched read loads on strobe rise with address and enables valid.
// [R15] Latches hold until disabled and strobe raised again.
`timescale 1ns/1ns
module prom_programmer #(
    parameter int ADDR_W = prom_prog_pkg::ADDR_W,
    parameter int STEP_CYC = prom_prog_pkg::STEP_DELAY_CYC,
    parameter int PULSE_CYC = prom_prog_pkg::FUSE_PULSE_CYC,
    parameter int REST_CYC = prom_prog_pkg::REST_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Request
    input wire logic req_valid,
    input wire logic req_program,
    input wire logic req_latched,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [2:0] req_bit,
    output logic req_ready,
    // Answer
    output logic resp_valid,
    output logic resp_fail,
    output logic [7:0] resp_data,
    // PROM pins
    output logic [ADDR_W-1:0] prom_addr,
    output logic chip_select_low_n,
    output logic chip_select_high,
    output logic strobe,
    output logic fuse_arm_input,
    output logic fuse_pulse_input,
    output logic [1:0] supply_sel,
    output logic [7:0] fuse_source_en,
    input wire logic [7:0] prom_data
);
    localparam int TW = 20;
    localparam int SETTLE = prom_prog_pkg::SETTLE_CYC;

    initial begin
        if (ADDR_W < 1 || ADDR_W > 16 || STEP_CYC < 1 || PULSE_CYC < 1 || REST_CYC < 1
            || PULSE_CYC >= (1 << TW) || REST_CYC >= (1 << TW))
            $error("prom_programmer: unusable parameters");
    end

    prom_prog_pkg::prog_state_t state_r;
    logic [TW-1:0] count_r;
    logic tmr_load_r;
    logic tmr_done;
    logic [2:0] bit_r;
    logic latched_r;

    wait_timer #(.WIDTH(TW)) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(tmr_load_r),
        .count(count_r),
        .done(tmr_done)
    );

    function automatic logic [7:0] one_hot(input logic [2:0] idx);
        one_hot = 8'h01 << idx;
    endfunction : one_hot

    // Sequencer; each step starts the timer and waits for it to run out
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= prom_prog_pkg::ST_IDLE;
            tmr_load_r <= 1'b0;
            count_r <= '0;
            bit_r <= 3'h0;
            latched_r <= 1'b0;
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_fail <= 1'b0;
            resp_data <= 8'h00;
            prom_addr <= '0;
            chip_select_low_n <= 1'b1;
            chip_select_high <= 1'b0;
            strobe <= 1'b1;
            fuse_arm_input <= 1'b0;
            fuse_pulse_input <= 1'b0;
            supply_sel <= prom_prog_pkg::SUPPLY_OFF;
            fuse_source_en <= 8'h00;
        end else begin
            tmr_load_r <= 1'b0;
            resp_valid <= 1'b0;
            unique case (state_r)
                prom_prog_pkg::ST_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        prom_addr <= req_addr;
                        bit_r <= req_bit;
                        latched_r <= req_latched;
                        chip_select_low_n <= 1'b0; // [R6] [R4]
                        chip_select_high <= 1'b1; // [R6] [R4]
                        tmr_load_r <= 1'b1;
                        if (req_program) begin
                            strobe <= 1'b1; // [R6]
                            supply_sel <= prom_prog_pkg::SUPPLY_PROG; // [R7] [R12]
                            count_r <= TW'(STEP_CYC);
                            state_r <= prom_prog_pkg::ST_ADDR;
                        end else begin
                            // Low then rise loads the latch with enables active [R14] [R3]
                            strobe <= ~req_latched; // [R1]
                            supply_sel <= prom_prog_pkg::SUPPLY_PROG;
                            count_r <= TW'(SETTLE);
                            state_r <= prom_prog_pkg::ST_READ;
                        end
                    end
                end
                prom_prog_pkg::ST_READ: begin
                    if (tmr_done) begin
                        if (latched_r && !strobe) begin
                            strobe <= 1'b1; // [R3] [R14]
                            tmr_load_r <= 1'b1;
                        end else begin
                            // Lowering strobe freezes the word for the holder [R2] [R15]
                            if (latched_r)
                                strobe <= 1'b0; // [R2]
                            resp_data <= prom_data;
                            resp_valid <= 1'b1;
                            resp_fail <= 1'b0;
                            state_r <= prom_prog_pkg::ST_IDLE;
                        end
                    end
                end
                prom_prog_pkg::ST_ADDR: if (tmr_done) begin
                    fuse_arm_input <= 1'b1; // [R7]
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_ARM;
                end
                prom_prog_pkg::ST_ARM: if (tmr_done) begin
                    fuse_source_en <= one_hot(bit_r); // [R8]
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_SRC;
                end
                prom_prog_pkg::ST_SRC: if (tmr_done) begin
                    fuse_pulse_input <= 1'b1; // [R9]
                    count_r <= TW'(PULSE_CYC);
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_PULSE;
                end
                prom_prog_pkg::ST_PULSE: if (tmr_done) begin
                    fuse_pulse_input <= 1'b0; // [R9]
                    count_r <= TW'(STEP_CYC);
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_HOLD;
                end
                prom_prog_pkg::ST_HOLD: if (tmr_done) begin
                    fuse_source_en <= 8'h00; // [R10]
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_DISARM;
                end
                prom_prog_pkg::ST_DISARM: if (tmr_done) begin
                    fuse_arm_input <= 1'b0; // [R11]
                    supply_sel <= prom_prog_pkg::SUPPLY_UPPER; // [R11]
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_VERIFY_HI;
                end
                prom_prog_pkg::ST_VERIFY_HI: if (tmr_done) begin
                    // A bit only ever fuses to 1, so a 0 here is a failed fuse [R5]
                    resp_fail <= ~prom_data[bit_r]; // [R11] [R5]
                    supply_sel <= prom_prog_pkg::SUPPLY_LOWER; // [R11]
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_VERIFY_LO;
                end
                prom_prog_pkg::ST_VERIFY_LO: if (tmr_done) begin
                    resp_fail <= resp_fail | ~prom_data[bit_r]; // [R11]
                    resp_data <= prom_data;
                    supply_sel <= prom_prog_pkg::SUPPLY_OFF; // [R13]
                    count_r <= TW'(REST_CYC);
                    tmr_load_r <= 1'b1;
                    state_r <= prom_prog_pkg::ST_REST;
                end
                prom_prog_pkg::ST_REST: if (tmr_done) begin
                    resp_valid <= 1'b1; // [R13]
                    state_r <= prom_prog_pkg::ST_IDLE;
                end
                default: state_r <= prom_prog_pkg::ST_IDLE;
            endcase
        end
    end

    // Cycle counter for the assertions' timing checks
    logic [TW-1:0] since_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            since_r <= '0;
        else if (tmr_load_r)
            since_r <= '0;
        else
            since_r <= since_r + TW'(1);
    end

    a_one_source: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
        $onehot0(fuse_source_en))
        else $error("more than one output sourced");

    a_fuse_selects: assert property (@(posedge clk_sys) disable iff (reset) // [R6]
        fuse_arm_input |-> (!chip_select_low_n && chip_select_high && strobe))
        else $error("selects or strobe wrong while armed");

    a_arm_delay: assert property (@(posedge clk_sys) disable iff (reset) // [R7]
        $rose(fuse_arm_input) |-> $past(since_r) >= TW'(STEP_CYC - 1))
        else $error("arm raised too early");

    a_source_armed: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
        $rose(|fuse_source_en) |-> fuse_arm_input && $past(since_r) >= TW'(STEP_CYC - 1))
        else $error("source applied early or unarmed");

    a_pulse_width: assert property (@(posedge clk_sys) disable iff (reset) // [R9]
        $fell(fuse_pulse_input) |-> $past(since_r) >= TW'(PULSE_CYC - 1))
        else $error("fuse pulse too short");

    a_pulse_source: assert property (@(posedge clk_sys) disable iff (reset) // [R9]
        fuse_pulse_input |-> (|fuse_source_en) && fuse_arm_input)
        else $error("pulse without source");

    a_source_off: assert property (@(posedge clk_sys) disable iff (reset) // [R10]
        $fell(|fuse_source_en) |-> !fuse_pulse_input && $past(since_r) >= TW'(STEP_CYC - 1))
        else $error("source removed too early");

    a_verify_disarmed: assert property (@(posedge clk_sys) disable iff (reset) // [R11]
        (supply_sel == prom_prog_pkg::SUPPLY_UPPER) |-> !fuse_arm_input && fuse_source_en == 8'h00)
        else $error("verify while armed");

    a_rest_off: assert property (@(posedge clk_sys) disable iff (reset) // [R13]
        (state_r == prom_prog_pkg::ST_REST) |-> supply_sel == prom_prog_pkg::SUPPLY_OFF)
        else $error("supply on during rest");

    a_latch_rise: assert property (@(posedge clk_sys) disable iff (reset) // [R3]
        (state_r == prom_prog_pkg::ST_READ && $rose(strobe)) |-> !chip_select_low_n
        && chip_select_high)
        else $error("strobe rose with enables off");
endmodule : prom_programmer

// ==== verification/prom_model.sv ====
/*
 * Behavioural fuse PROM with output latches, plus a watcher of the fusing sequence.
 * Assumes pins change just after clk_sys edges; data comes back registered on clk_sys.
 */
`timescale 1ns/1ns
module prom_model #(
    parameter int ADDR_W = 9,
    parameter int STEP_CYC = 4,
    parameter int PULSE_CYC = 20,
    parameter int REST_CYC = 30
) (
    // Clock
    input wire logic clk_sys,
    // Pins from the programmer
    input wire logic [ADDR_W-1:0] prom_addr,
    input wire logic chip_select_low_n,
    input wire logic chip_select_high,
    input wire logic strobe,
    input wire logic fuse_arm_input,
    input wire logic fuse_pulse_input,
    input wire logic [1:0] supply_sel,
    input wire logic [7:0] fuse_source_en,
    output logic [7:0] prom_data,
    // Test controls
    input wire logic stuck,
    output logic seq_err_r
);
    logic [7:0] mem_r [2**ADDR_W];
    logic [7:0] word_r = 8'h00;
    logic en_r = 1'b0;
    logic pulse_q_r = 1'b0;
    logic fused_r = 1'b0;
    logic [ADDR_W+11:0] pins_q_r = '0;
    logic [31:0] gap_r = 32'h0, width_r = 32'h0, off_r = 32'h0;
    // One process owns each output register
    logic [7:0] dout_r = 8'h00;
    logic err_r = 1'b0;
    wire sel = !chip_select_low_n && chip_select_high;
    wire [9:0] watch = {fuse_arm_input, fuse_pulse_input, fuse_source_en};
    wire [ADDR_W+11:0] pins = {prom_addr, supply_sel, watch};

    assign prom_data = dout_r;
    assign seq_err_r = err_r;

    initial begin
        foreach (mem_r[i]) mem_r[i] = 8'h00;
    end

    always @(posedge clk_sys) begin
        if (strobe) begin
            word_r <= mem_r[prom_addr];
            en_r <= sel;
        end // Strobe low keeps word and enable
        // Floating outputs toggle so a stale value never looks valid
        dout_r <= en_r ? word_r : ~dout_r;
        pulse_q_r <= fuse_pulse_input;
        if (fuse_pulse_input && !pulse_q_r) begin
            if (!$onehot(fuse_source_en)) err_r <= 1'b1;
            if (!sel || !strobe || !fuse_arm_input || supply_sel != prom_prog_pkg::SUPPLY_PROG) begin
                err_r <= 1'b1;
            end else if (!stuck) begin
                mem_r[prom_addr] <= mem_r[prom_addr] | fuse_source_en;
            end
            fused_r <= 1'b1;
        end
        width_r <= fuse_pulse_input ? width_r + 1 : 32'h0;
        if (!fuse_pulse_input && pulse_q_r && width_r < PULSE_CYC) err_r <= 1'b1;
        pins_q_r <= pins;
        if (pins != pins_q_r) begin
            if (watch != pins_q_r[9:0] && gap_r < STEP_CYC - 1) err_r <= 1'b1;
            gap_r <= 32'h0;
        end else begin
            gap_r <= gap_r + 1;
        end
        off_r <= (supply_sel == prom_prog_pkg::SUPPLY_OFF) ? off_r + 1 : 32'h0;
        if (supply_sel == prom_prog_pkg::SUPPLY_PROG && fused_r && off_r != 0) begin
            if (off_r < REST_CYC - 1) err_r <= 1'b1;
            fused_r <= 1'b0;
        end
    end
endmodule : prom_model

// ==== verification/fuse_prom_latched_read_test.sv ====
/*
 * Self-checking bench for prom_programmer against prom_model.
 * Assumes short step, pulse and rest counts; expected words come from a shadow image.
 */
`timescale 1ns/1ns
module fuse_prom_latched_read_test;
    localparam int STEP = 4;
    localparam int PULSE = 20;
    localparam int REST = 30;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0, req_program = 1'b0, req_latched = 1'b0, stuck = 1'b0;
    logic [8:0] req_addr = 9'h000;
    logic [2:0] req_bit = 3'h0;
    logic req_ready, resp_valid, resp_fail, chip_select_low_n, chip_select_high, strobe;
    logic fuse_arm_input, fuse_pulse_input, seq_err;
    logic [7:0] resp_data, fuse_source_en, prom_data;
    logic [8:0] prom_addr;
    logic [1:0] supply_sel;
    logic [31:0] rand_r = 32'h00010E8A;
    logic [7:0] img [512];
    logic [8:0] exp_q [$];
    int errors = 0, n_tests = 0;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    always #2 clk_sys = ~clk_sys;

    prom_programmer #(.ADDR_W(9), .STEP_CYC(STEP), .PULSE_CYC(PULSE), .REST_CYC(REST)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req_program(req_program),
        .req_latched(req_latched), .req_addr(req_addr), .req_bit(req_bit), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_fail(resp_fail), .resp_data(resp_data),
        .prom_addr(prom_addr), .chip_select_low_n(chip_select_low_n),
        .chip_select_high(chip_select_high), .strobe(strobe), .fuse_arm_input(fuse_arm_input),
        .fuse_pulse_input(fuse_pulse_input), .supply_sel(supply_sel),
        .fuse_source_en(fuse_source_en), .prom_data(prom_data));

    prom_model #(.ADDR_W(9), .STEP_CYC(STEP), .PULSE_CYC(PULSE), .REST_CYC(REST)) i_model (
        .clk_sys(clk_sys), .prom_addr(prom_addr), .chip_select_low_n(chip_select_low_n),
        .chip_select_high(chip_select_high), .strobe(strobe), .fuse_arm_input(fuse_arm_input),
        .fuse_pulse_input(fuse_pulse_input), .supply_sel(supply_sel),
        .fuse_source_en(fuse_source_en), .prom_data(prom_data), .stuck(stuck),
        .seq_err_r(seq_err));

    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Waits for the previous answer too, so the ready drop, which lasts from acceptance until the cycle after the answer, is never raced
    task automatic wait_idle();
        int n;
        n = 0;
        while ((exp_q.size() != 0 || req_ready !== 1'b1) && n < 5000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 5000) begin
            errors++;
            $display("[FAIL] request ready expected 1 seen timeout");
            close_out();
        end
    endtask : wait_idle

    task automatic request(input logic prog, lat, input logic [8:0] a, input logic [2:0] b,
                           input logic stk);
        wait_idle();
        stuck = stk;
        if (prog && !stk) img[a] = img[a] | (8'h01 << b);
        exp_q.push_back({prog & stk, img[a]});
        req_valid = 1'b1;
        req_program = prog;
        req_latched = lat;
        req_addr = a;
        req_bit = b;
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
    endtask : request

    always @(negedge clk_sys) begin
        if (resp_valid === 1'b1) begin
            if (exp_q.size() == 0) check("spare answer", 9'h000, 9'h100);
            else check("answer", exp_q.pop_front(), {resp_fail, resp_data});
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        close_out();
    end

    initial begin
        logic [8:0] a, a2;
        logic [2:0] b;
        foreach (img[i]) img[i] = 8'h00;
        repeat (16) @(posedge clk_sys);
        #1;
        check("selects in reset", 9'h002, {7'h00, chip_select_low_n, chip_select_high});
        reset = 1'b0;
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 4; i++) begin
            rand_r = lfsr_next(rand_r);
            request(1'b0, rand_r[12], rand_r[8:0], 3'h0, 1'b0);
        end
        a = rand_r[8:0];
        b = rand_r[11:9];
        a2 = a ^ 9'h1FF;
        request(1'b1, 1'b0, a, b, 1'b0);
        request(1'b1, 1'b0, a, b + 3'h1, 1'b0);
        request(1'b1, 1'b0, a2, 3'h7, 1'b0);
        request(1'b0, 1'b0, a, 3'h0, 1'b0);
        request(1'b0, 1'b1, a, 3'h0, 1'b0);
        request(1'b0, 1'b1, a2, 3'h0, 1'b0);
        request(1'b0, 1'b0, a2, 3'h0, 1'b0);
        request(1'b1, 1'b0, a2, 3'h0, 1'b1);
        request(1'b0, 1'b1, a, 3'h0, 1'b0);
        wait_idle();
        check("fuse sequence", 9'h000, {8'h00, seq_err});
        close_out();
    end
endmodule : fuse_prom_latched_read_test
